// File: design/sdram_timing_pkg.sv
/*
 * Constants, types and helpers for the command-spacing controller of a
 * DDR2 SDRAM. Assumes a 50 MHz system clock. The memory clock is made by
 * dividing that clock by two.
 */
package sdram_timing_pkg;

    localparam int CLK_PERIOD_PS = 20000;
    localparam int CK_DIV        = 2;
    localparam int CK_PERIOD_PS  = CLK_PERIOD_PS * CK_DIV;

    // a least time rounds up to whole memory clocks, a longest time rounds down
    function automatic int ck_ceil(input int ps);
        int n;
        n = (ps + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
        return (n < 1) ? 1 : n;
    endfunction

    function automatic int ck_floor(input int ps);
        int n;
        n = ps / CK_PERIOD_PS;
        return (n < 1) ? 1 : n;
    endfunction

    localparam int GAP_W = 8;
    typedef logic [GAP_W-1:0] gap_t;

    localparam int MODE_SET_GAP             = 2;
    localparam int SELFREF_EXIT_READ_GAP    = 200;
    localparam int REFRESH_CYCLE_TIME_PS    = 127500;
    localparam int SELFREF_EXIT_MARGIN_PS   = 10000;
    localparam int SELFREF_EXIT_OTHER_GAP   =
        ck_ceil(REFRESH_CYCLE_TIME_PS + SELFREF_EXIT_MARGIN_PS);
    localparam int REFRESH_CYCLE_GAP        = ck_ceil(REFRESH_CYCLE_TIME_PS);
    localparam int PRECHARGE_PD_EXIT_GAP    = 2;
    localparam int FAST_ACTIVE_PD_EXIT_GAP  = 2;
    localparam int SLOW_ACTIVE_PD_EXIT_BASE = 7;
    localparam int CLOCK_ENABLE_MIN_PULSE   = 3;
    localparam int REFRESH_INTERVAL_NS      = 7800;
    localparam int REFRESH_INTERVAL_HOT_NS  = 3900;
    localparam int REFRESH_INTERVAL         = ck_floor(REFRESH_INTERVAL_NS * 1000);
    localparam int REFRESH_INTERVAL_HOT     = ck_floor(REFRESH_INTERVAL_HOT_NS * 1000);
    localparam int WRITE_TO_READ_PS         = 7500;
    localparam int WRITE_TO_READ_MIN        = 2;
    localparam int WRITE_TO_READ_GAP        =
        (ck_ceil(WRITE_TO_READ_PS) < WRITE_TO_READ_MIN) ? WRITE_TO_READ_MIN
                                                        : ck_ceil(WRITE_TO_READ_PS);
    localparam int REFRESH_OWED_MAX         = 8;
    localparam logic [3:0] OWED_MAX         = 4'h8;
    localparam logic [3:0] OWED_URGENT      = 4'h7;

    // mode register fields
    localparam logic [2:0] BA_MODE          = 3'h0;
    localparam logic [2:0] BA_EXT_MODE      = 3'h1;
    localparam int         MR_SLOW_EXIT_BIT = 12;
    localparam int         MR_CAS_LO        = 4;
    localparam int         EMR_AL_LO        = 3;
    localparam logic [2:0] CAS_RESET        = 3'h3;
    localparam logic [2:0] AL_RESET         = 3'h0;
    localparam int         PRECHARGE_ALL_BIT = 10;

    // write strobe steps, one system clock (half a memory clock) each
    localparam logic [2:0] STEP_IDLE = 3'h0;
    localparam logic [2:0] STEP_PRE  = 3'h1;
    localparam logic [2:0] STEP_LAST = 3'h5;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_MODE_SET, CMD_REFRESH, CMD_SELFREF_ENTER, CMD_SELFREF_EXIT,
        CMD_PD_ENTER, CMD_PD_EXIT, CMD_ACTIVATE, CMD_PRECHARGE_ALL, CMD_READ, CMD_WRITE
    } cmd_e;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_PD      = 3'b010,
        ST_SELFREF = 3'b100
    } state_e;

    typedef struct packed {
        cmd_e        cmd;
        logic [2:0]  ba;
        logic [13:0] addr;
    } req_s;

    typedef struct packed {
        logic        cke;
        logic        cs_b;
        logic        ras_b;
        logic        cas_b;
        logic        we_b;
        logic [2:0]  ba;
        logic [13:0] addr;
    } mem_pins_s;

    localparam mem_pins_s PINS_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0000};

    function automatic mem_pins_s pins_for(input req_s r, input logic cke);
        mem_pins_s p;
        p = '{cke, 1'b0, 1'b1, 1'b1, 1'b1, r.ba, r.addr};
        unique case (r.cmd)
            CMD_MODE_SET:      {p.ras_b, p.cas_b, p.we_b} = 3'h0;
            CMD_REFRESH,
            CMD_SELFREF_ENTER: {p.ras_b, p.cas_b, p.we_b} = 3'h1;
            CMD_ACTIVATE:      {p.ras_b, p.cas_b, p.we_b} = 3'h3;
            CMD_PRECHARGE_ALL: {p.ras_b, p.cas_b, p.we_b} = 3'h2;
            CMD_READ:          {p.ras_b, p.cas_b, p.we_b} = 3'h5;
            CMD_WRITE:         {p.ras_b, p.cas_b, p.we_b} = 3'h4;
            default:           {p.ras_b, p.cas_b, p.we_b} = 3'h7;
        endcase
        if (r.cmd == CMD_PRECHARGE_ALL)
            p.addr[PRECHARGE_ALL_BIT] = 1'b1;
        return p;
    endfunction

endpackage

// File: design/gap_timer.sv
/*
 * Least-spacing timer counted in memory clocks. A load never shortens a
 * wait already running. Assumes tick is a one-cycle enable per memory clock.
 */
`timescale 1ns/1ps
module gap_timer
    import sdram_timing_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic tick,
    input  wire logic load,
    input  wire gap_t value,
    output logic      done
);
    gap_t cnt_q;
    gap_t cnt_dec;
    gap_t want;

    // a gap of n clocks lets the next command go on the n-th tick after this one
    assign cnt_dec = (tick && cnt_q != '0) ? gap_t'(cnt_q - 8'h01) : cnt_q;
    assign want    = (value == '0) ? '0 : gap_t'(value - 8'h01);
    assign done    = (cnt_q == '0);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cnt_q <= '0;
        else
            cnt_q <= (load && want > cnt_dec) ? want : cnt_dec;
    end
endmodule // gap_timer

// File: design/sdram_cmd_timing.sv
/*
 * Host-side command sequencer for a DDR2 SDRAM: spaces mode sets, power-down
 * and self-refresh entry and exit, refreshes, reads and writes, paces
 * refresh, and frames the write strobe. Assumes requests are held until
 * taken, burst length four, and pins that are sampled on the rising edge of
 * the divided memory clock it drives out.
 */
`timescale 1ns/1ps
// How it works
// - after a mode set, wait two memory clocks before any command
// - after self-refresh exit, wait 200 clocks before a read
// - after self-refresh exit, non-read commands wait refresh cycle time plus 10 ns
// - after precharge power-down exit, wait two clocks before non-read commands
// - after fast active power-down exit, wait two clocks before a read
// - slow active power-down exit waits grade base minus additive latency before a read
// - clock enable holds each level at least three clocks
// - refresh on average every 7.8 us, 3.9 us when hot
// - write strobe has a preamble of at least 0.35 and postamble 0.4 to 0.6 clock
// - write preamble setup at least zero, hold at least a quarter clock
// - first rising write strobe edge lies within a quarter clock of a rising clock edge
// - write strobe high and low phases last at least 0.35 clock
// - falling write strobe edges stay 0.2 clock away from rising clock edges
// - wait 7.5 ns after the last write data before a read
// - mode register bit 12 selects fast or slow active power-down exit
// - write-to-read spacing is never below two clocks
// - no more than eight refreshes may be owed
// - least time limits convert to clocks by rounding up, refresh intervals by rounding down
module sdram_cmd_timing
    import sdram_timing_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire logic      hot_temp,
    input  wire logic      req_valid,
    input  wire req_s      req,
    output logic           req_taken,
    output mem_pins_s      mem_pins,
    output logic           mem_ck,
    output logic           dqs_o,
    output logic           dqs_oe_b,
    output logic [3:0]     refresh_owed
);
    state_e      state_q;
    state_e      state_d;
    logic        ck_q;
    logic        taken_q;
    mem_pins_s   pins_q;
    logic        slow_exit_q;
    logic [2:0]  cas_q;
    logic [2:0]  al_q;
    logic        bank_open_q;
    logic [3:0]  owed_q;
    gap_t        ref_cnt_q;
    gap_t        wr_wait_q;
    logic [2:0]  step_q;
    logic [2:0]  step_d;
    logic        dqs_q;
    logic        dqs_oe_b_q;

    logic        tick;
    logic        read_done;
    logic        other_done;
    logic        cke_done;
    logic        urgent;
    logic        wr_busy;
    logic        is_read;
    logic        legal;
    logic        host_ref;
    logic        host_pdx;
    logic        iss;
    logic        iss_user;
    req_s        sel;
    logic        ld_read;
    logic        ld_other;
    gap_t        gap_read;
    gap_t        gap_other;
    logic        ref_due;
    logic        ref_paid;
    logic        wr_end;
    gap_t        slow_gap;
    gap_t        wl_halves;
    logic        cke_next;

    // the memory clock is high in the cycle of a tick and low after it, so pins set on a
    // tick are stable across the next rising memory clock edge
    assign tick = ck_q;

    assign slow_gap  = (al_q >= 3'(SLOW_ACTIVE_PD_EXIT_BASE)) ? 8'h01
                       : gap_t'(SLOW_ACTIVE_PD_EXIT_BASE - int'(al_q));
    assign wl_halves = gap_t'((int'(al_q) + int'(cas_q) - 1) * CK_DIV);
    assign urgent    = (owed_q >= OWED_URGENT);
    assign wr_busy   = (wr_wait_q != '0) || (step_q != STEP_IDLE);
    assign is_read   = (req.cmd == CMD_READ);

    always_comb
    begin
        legal = 1'b0;
        unique case (state_q)
            ST_IDLE:
                unique case (req.cmd)
                    CMD_MODE_SET,
                    CMD_REFRESH:       legal = !bank_open_q;
                    CMD_SELFREF_ENTER: legal = !bank_open_q && cke_done;
                    CMD_PD_ENTER:      legal = cke_done && !urgent && !wr_busy;
                    CMD_ACTIVATE:      legal = !urgent;
                    CMD_PRECHARGE_ALL: legal = !wr_busy;
                    CMD_READ,
                    CMD_WRITE:         legal = bank_open_q && !urgent && !wr_busy;
                    default:           legal = 1'b0;
                endcase
            ST_PD:      legal = (req.cmd == CMD_PD_EXIT) && cke_done;
            ST_SELFREF: legal = (req.cmd == CMD_SELFREF_EXIT) && cke_done;
            default:    legal = 1'b0;
        endcase
    end

    // owed refreshes go out when the user is idle, or first when near the limit
    assign host_ref = (state_q == ST_IDLE) && (owed_q != 4'h0) && !bank_open_q
                      && other_done && (urgent || !req_valid);
    assign host_pdx = (state_q == ST_PD) && urgent && cke_done;
    assign iss_user = req_valid && legal && (is_read ? read_done : other_done)
                      && !host_ref && !host_pdx;
    assign iss      = tick && (iss_user || host_ref || host_pdx);

    always_comb
    begin
        sel = req;
        if (host_ref)
            sel.cmd = CMD_REFRESH;
        else if (host_pdx)
            sel.cmd = CMD_PD_EXIT;
    end

    always_comb
    begin
        state_d   = state_q;
        ld_read   = 1'b0;
        ld_other  = 1'b0;
        gap_read  = '0;
        gap_other = '0;
        cke_next  = pins_q.cke;
        if (iss)
        begin
            unique case (sel.cmd)
                CMD_MODE_SET:
                begin
                    ld_read   = 1'b1;
                    ld_other  = 1'b1;
                    gap_read  = gap_t'(MODE_SET_GAP);
                    gap_other = gap_t'(MODE_SET_GAP);
                end
                CMD_REFRESH:
                begin
                    ld_read   = 1'b1;
                    ld_other  = 1'b1;
                    gap_read  = gap_t'(REFRESH_CYCLE_GAP);
                    gap_other = gap_t'(REFRESH_CYCLE_GAP);
                end
                CMD_SELFREF_ENTER:
                begin
                    state_d  = ST_SELFREF;
                    cke_next = 1'b0;
                end
                CMD_SELFREF_EXIT:
                begin
                    state_d   = ST_IDLE;
                    cke_next  = 1'b1;
                    ld_read   = 1'b1;
                    ld_other  = 1'b1;
                    gap_read  = gap_t'(SELFREF_EXIT_READ_GAP);
                    gap_other = gap_t'(SELFREF_EXIT_OTHER_GAP);
                end
                CMD_PD_ENTER:
                begin
                    state_d  = ST_PD;
                    cke_next = 1'b0;
                end
                CMD_PD_EXIT:
                begin
                    state_d   = ST_IDLE;
                    cke_next  = 1'b1;
                    ld_read   = 1'b1;
                    ld_other  = 1'b1;
                    gap_other = gap_t'(PRECHARGE_PD_EXIT_GAP);
                    gap_read  = !bank_open_q ? gap_t'(PRECHARGE_PD_EXIT_GAP)
                              : slow_exit_q ? slow_gap
                              : gap_t'(FAST_ACTIVE_PD_EXIT_GAP);
                end
                default: ;
            endcase
        end
        else if (wr_end)
        begin
            ld_read  = 1'b1;
            gap_read = gap_t'(WRITE_TO_READ_GAP);
        end
    end

    gap_timer u_read_gap (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (tick),
        .load  (ld_read),
        .value (gap_read),
        .done  (read_done)
    );

    gap_timer u_other_gap (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (tick),
        .load  (ld_other),
        .value (gap_other),
        .done  (other_done)
    );

    gap_timer u_cke_pulse (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (tick),
        .load  (iss && cke_next != pins_q.cke),
        .value (gap_t'(CLOCK_ENABLE_MIN_PULSE)),
        .done  (cke_done)
    );

    // write strobe: low preamble half clock, two high/low pairs, then release
    assign wr_end = (step_q == STEP_LAST);
    assign step_d = (wr_wait_q == 8'h01) ? STEP_PRE
                  : (step_q == STEP_IDLE || wr_end) ? STEP_IDLE
                  : 3'(step_q + 3'h1);

    assign ref_due = tick && (state_q != ST_SELFREF) && (ref_cnt_q == '0);
    // a refresh sent ahead of time owes nothing back, so the count cannot wrap
    assign ref_paid = iss && sel.cmd == CMD_REFRESH && owed_q != 4'h0;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_q    <= ST_IDLE;
            ck_q       <= 1'b0;
            taken_q    <= 1'b0;
            pins_q     <= PINS_RESET;
            step_q     <= STEP_IDLE;
            dqs_q      <= 1'b0;
            dqs_oe_b_q <= 1'b1;
            wr_wait_q  <= '0;
        end
        else
        begin
            state_q    <= state_d;
            ck_q       <= !ck_q;
            taken_q    <= iss && iss_user;
            step_q     <= step_d;
            dqs_q      <= (step_d == 3'h2) || (step_d == 3'h4);
            dqs_oe_b_q <= (step_d == STEP_IDLE);
            if (iss)
                pins_q <= pins_for(sel, cke_next);
            else if (tick)
                pins_q <= '{pins_q.cke, 1'b1, 1'b1, 1'b1, 1'b1, pins_q.ba, pins_q.addr};
            if (iss && sel.cmd == CMD_WRITE)
                wr_wait_q <= wl_halves;
            else if (wr_wait_q != '0)
                wr_wait_q <= gap_t'(wr_wait_q - 8'h01);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            slow_exit_q <= 1'b0;
            cas_q       <= CAS_RESET;
            al_q        <= AL_RESET;
            bank_open_q <= 1'b0;
        end
        else if (iss && sel.cmd == CMD_MODE_SET)
        begin
            if (sel.ba == BA_MODE)
            begin
                slow_exit_q <= sel.addr[MR_SLOW_EXIT_BIT];
                cas_q       <= sel.addr[MR_CAS_LO +: 3];
            end
            else if (sel.ba == BA_EXT_MODE)
                al_q <= sel.addr[EMR_AL_LO +: 3];
        end
        else if (iss && sel.cmd == CMD_ACTIVATE)
            bank_open_q <= 1'b1;
        else if (iss && sel.cmd == CMD_PRECHARGE_ALL)
            bank_open_q <= 1'b0;
    end

    // a refresh falling due in the same tick as one issued is still counted
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            owed_q    <= 4'h0;
            ref_cnt_q <= gap_t'(REFRESH_INTERVAL);
        end
        else
        begin
            if (iss && sel.cmd == CMD_SELFREF_ENTER)
                owed_q <= 4'h0;
            else if (owed_q != OWED_MAX || ref_paid)
                owed_q <= 4'(owed_q + {3'h0, ref_due} - {3'h0, ref_paid});
            if (ref_due || (iss && sel.cmd == CMD_SELFREF_EXIT))
                ref_cnt_q <= hot_temp ? gap_t'(REFRESH_INTERVAL_HOT - 1)
                                      : gap_t'(REFRESH_INTERVAL - 1);
            else if (tick && state_q != ST_SELFREF)
                ref_cnt_q <= gap_t'(ref_cnt_q - 8'h01);
        end
    end

    assign req_taken    = taken_q;
    assign mem_pins     = pins_q;
    assign mem_ck       = ck_q;
    assign dqs_o        = dqs_q;
    assign dqs_oe_b     = dqs_oe_b_q;
    assign refresh_owed = owed_q;

    // helpers for the checks below; each counts memory clocks as of the coming tick
    logic [7:0] since_srx_q;
    logic [7:0] since_apx_q;
    gap_t       apx_gap_q;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            since_srx_q <= 8'hFF;
            since_apx_q <= 8'hFF;
            apx_gap_q   <= '0;
        end
        else
        begin
            if (iss && sel.cmd == CMD_SELFREF_EXIT)
                since_srx_q <= 8'h01;
            else if (tick && since_srx_q != 8'hFF)
                since_srx_q <= 8'(since_srx_q + 8'h01);
            if (iss && sel.cmd == CMD_PD_EXIT && bank_open_q)
            begin
                since_apx_q <= 8'h01;
                apx_gap_q   <= gap_read;
            end
            else if (tick && since_apx_q != 8'hFF)
                since_apx_q <= 8'(since_apx_q + 8'h01);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_quiet3;
        !iss [*3];
    endsequence

    a_mode_set_gap: assert property (iss && sel.cmd == CMD_MODE_SET |=> s_quiet3)
        else $error("command too soon after mode set");
    a_selfref_read_gap: assert property (iss && sel.cmd == CMD_READ
                                         |-> since_srx_q >= 8'(SELFREF_EXIT_READ_GAP))
        else $error("read too soon after self-refresh exit");
    a_selfref_other_gap: assert property (iss && sel.cmd == CMD_SELFREF_EXIT
                                          |=> !iss [*7])
        else $error("command too soon after self-refresh exit");
    a_pd_exit_gap: assert property (iss && sel.cmd == CMD_PD_EXIT |=> s_quiet3)
        else $error("command too soon after power-down exit");
    a_active_exit_read: assert property (iss && sel.cmd == CMD_READ
                                         |-> since_apx_q >= apx_gap_q)
        else $error("read too soon after active power-down exit");
    a_cke_pulse_width: assert property ($changed(pins_q.cke) |=> $stable(pins_q.cke) [*5])
        else $error("clock enable pulse too short");
    a_owed_bound: assert property (owed_q <= OWED_MAX)
        else $error("too many refreshes owed");
    a_preamble_low: assert property ($fell(dqs_oe_b_q) |-> !dqs_q ##1 dqs_q)
        else $error("write preamble wrong");
    a_strobe_rise_align: assert property (!dqs_oe_b_q && $rose(dqs_q) |-> $rose(ck_q))
        else $error("write strobe rise off clock edge");
    a_strobe_fall_clear: assert property (!dqs_oe_b_q && $fell(dqs_q) |-> $fell(ck_q))
        else $error("write strobe fall near rising clock");
    a_write_read_gap: assert property (wr_end |=> !(iss && sel.cmd == CMD_READ) [*2])
        else $error("read too soon after write data");
endmodule // sdram_cmd_timing

// File: dv/ddr2_mem_model.sv
/*
 * Behavioural DDR2 memory at the far side of the command pins. It counts
 * spacing faults of the controller in viol and issued refreshes in refs.
 * Assumes pins are sampled on the rising edge of mem_ck.
 */
`timescale 1ns/1ps
module ddr2_mem_model
    import sdram_timing_pkg::*;
(
    input  wire logic      mem_ck,
    input  wire mem_pins_s pins,
    output int             viol,
    output int             refs
);
    int         cyc   = 0;
    int         t_mrs = -100;
    int         t_cke = -100;
    int         t_wr  = -100;
    int         cl    = 3;
    int         al    = 0;
    int         need;
    logic       cke_q = 1'b0;
    logic       sr_q  = 1'b0;
    logic       act_q = 1'b0;
    logic       pda_q = 1'b0;
    logic       slw_q = 1'b0;
    logic [2:0] c;
    logic       rd;

    initial
    begin
        viol = 0;
        refs = 0;
    end

    // read strobe, calibration and termination outputs are not modelled
    always @(posedge mem_ck)
    begin
        cyc = cyc + 1;
        c = {pins.ras_b, pins.cas_b, pins.we_b};
        rd = !pins.cs_b && c == 3'h5;
        if (pins.cke !== cke_q)
        begin
            if (cyc - t_cke < 3) viol++;
            if (!pins.cke) sr_q = !pins.cs_b && c == 3'h1;
            if (!pins.cke) pda_q = act_q;
            t_cke = cyc;
            cke_q = pins.cke;
        end
        else if (!pins.cs_b && c != 3'h7)
        begin
            if (cyc - t_mrs < 2) viol++;
            // exit waits round up to whole 40 ns clocks
            if (sr_q) need = rd ? 200 : (127500 + 10000 + 39999) / 40000;
            else if (rd && pda_q && slw_q) need = SLOW_ACTIVE_PD_EXIT_BASE - al;
            else need = 2;
            if (cyc - t_cke < need) viol++;
            if (rd && cyc - t_wr < al + cl - 1 + 4) viol++;
            if (c == 3'h0) t_mrs = cyc;
            if (c == 3'h0 && pins.ba == 3'h0) cl = pins.addr[6:4];
            if (c == 3'h0 && pins.ba == 3'h0) slw_q = pins.addr[12];
            if (c == 3'h0 && pins.ba == 3'h1) al = pins.addr[5:3];
            if (c == 3'h1) refs++;
            if (c == 3'h3) act_q = 1'b1;
            if (c == 3'h2) act_q = 1'b0;
            if (c == 3'h4) t_wr = cyc;
        end
    end
endmodule // ddr2_mem_model

// File: dv/testbench.sv
/*
 * Self-checking bench for the command sequencer with a memory model.
 * Assumes the package, the design and the model are compiled first.
 */
`timescale 1ns/1ps
module testbench;
    import sdram_timing_pkg::*;
    logic       clk;
    logic       rst_b;
    logic       hot_temp;
    logic       req_valid;
    req_s       req;
    logic       req_taken;
    mem_pins_s  mem_pins;
    logic       mem_ck;
    logic       dqs_o;
    logic       dqs_oe_b;
    logic [3:0] refresh_owed;
    int         fail_count = 0;
    int         tests_run = 0;
    int         viol;
    int         refs;
    int         cyc = 0;
    int         t_tk;
    int         t0;
    int         cl;
    int         al;
    int         wl;
    logic [2:0] exp_q[$];

    sdram_cmd_timing dut_u (.clk(clk), .rst_b(rst_b), .hot_temp(hot_temp),
        .req_valid(req_valid), .req(req), .req_taken(req_taken), .mem_pins(mem_pins),
        .mem_ck(mem_ck), .dqs_o(dqs_o), .dqs_oe_b(dqs_oe_b), .refresh_owed(refresh_owed));
    ddr2_mem_model mem_u (.mem_ck(mem_ck), .pins(mem_pins), .viol(viol), .refs(refs));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s got %0h expected %0h", $time, s, got, exp);
        end
    endtask

    always @(negedge clk)
        if (req_taken === 1'b1)
            chk({mem_pins.cs_b, mem_pins.ras_b, mem_pins.cas_b, mem_pins.we_b},
                {1'b0, exp_q.pop_front()}, "command pins");

    // code is the ras, cas, we pattern the command must show
    task automatic send(input cmd_e c, input logic [2:0] ba, input logic [13:0] a,
                        input logic [2:0] code);
        int n;
        n = 0;
        @(negedge clk);
        req = '{c, ba, a};
        req_valid = 1'b1;
        exp_q.push_back(code);
        do
        begin
            @(negedge clk);
            n++;
        end
        while (req_taken !== 1'b1 && n < 2000);
        chk(n < 2000, 1, "request taken");
        req_valid = 1'b0;
        t_tk = cyc;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #(20 * 30000);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        rst_b = 1'b0;
        hot_temp = 1'b0;
        req_valid = 1'b0;
        req = '0;
        void'($urandom(32'h1D6E));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        chk(mem_pins, PINS_RESET, "reset pins");
        chk({dqs_oe_b, refresh_owed}, 5'h10, "reset strobe");
        // clock enable rests low after reset; a power-down pair raises it
        send(CMD_PD_ENTER, 3'h0, 14'h0000, 3'h7);
        send(CMD_PD_EXIT, 3'h0, 14'h0000, 3'h7);
        for (int i = 0; i < 2; i++)
        begin
            cl = (i == 0) ? 3 : 3 + $urandom % 3;
            al = $urandom % 2;
            wl = al + cl - 1;
            send(CMD_MODE_SET, 3'h0, 14'(cl << 4), 3'h0);
            t0 = t_tk;
            send(CMD_MODE_SET, 3'h1, 14'(al << 3), 3'h0);
            chk(t_tk - t0 >= 4, 1, "mode gap");
            send(CMD_ACTIVATE, 3'($urandom), 14'($urandom), 3'h3);
            send(CMD_WRITE, 3'h0, 14'h0000, 3'h4);
            t0 = t_tk;
            for (int k = 1; k <= 2 * wl + 5; k++)
            begin
                @(negedge clk);
                if (k >= 2 * wl - 1)
                    chk(dqs_oe_b, k < 2 * wl || k == 2 * wl + 5, "strobe enable");
                if (k >= 2 * wl && k < 2 * wl + 5)
                    chk(dqs_o, (k - 2 * wl) % 2, "strobe level");
                if (k == 2 * wl + 1)
                    chk(mem_ck, 1, "first strobe edge");
            end
            send(CMD_READ, 3'h0, 14'h0000, 3'h5);
            chk(t_tk - t0 >= 2 * (wl + 4), 1, "write to read");
            send(CMD_PRECHARGE_ALL, 3'h0, 14'h0000, 3'h2);
            $display("test write strobe %0d finished", i);
        end
        for (int slow = 0; slow < 2; slow++)
        begin
            send(CMD_MODE_SET, 3'h0, 14'((slow << 12) | 14'h0030), 3'h0);
            send(CMD_MODE_SET, 3'h1, 14'h0000, 3'h0);
            send(CMD_ACTIVATE, 3'($urandom), 14'($urandom), 3'h3);
            send(CMD_PD_ENTER, 3'h0, 14'h0000, 3'h7);
            t0 = t_tk;
            send(CMD_PD_EXIT, 3'h0, 14'h0000, 3'h7);
            chk(t_tk - t0 >= 6, 1, "clock enable low");
            t0 = t_tk;
            send(CMD_READ, 3'h0, 14'h0000, 3'h5);
            chk(t_tk - t0 >= 2 * (slow ? SLOW_ACTIVE_PD_EXIT_BASE : 2), 1, "pd read");
            send(CMD_PRECHARGE_ALL, 3'h0, 14'h0000, 3'h2);
            send(CMD_PD_ENTER, 3'h0, 14'h0000, 3'h7);
            send(CMD_PD_EXIT, 3'h0, 14'h0000, 3'h7);
            t0 = t_tk;
            send(CMD_ACTIVATE, 3'h0, 14'($urandom), 3'h3);
            chk(t_tk - t0 >= 4, 1, "pd other");
            send(CMD_PRECHARGE_ALL, 3'h0, 14'h0000, 3'h2);
            $display("test power down %0d finished", slow);
        end
        send(CMD_REFRESH, 3'h0, 14'h0000, 3'h1);
        send(CMD_SELFREF_ENTER, 3'h0, 14'h0000, 3'h1);
        send(CMD_SELFREF_EXIT, 3'h0, 14'h0000, 3'h7);
        t0 = t_tk;
        send(CMD_ACTIVATE, 3'h0, 14'($urandom), 3'h3);
        chk(t_tk - t0 >= 8, 1, "self refresh other");
        send(CMD_READ, 3'h0, 14'h0000, 3'h5);
        chk(t_tk - t0 >= 400, 1, "self refresh read");
        send(CMD_PRECHARGE_ALL, 3'h0, 14'h0000, 3'h2);
        $display("test self refresh finished");
        // a read with no open bank is refused, so refreshes fall owed behind it
        t0 = refs;
        @(negedge clk);
        hot_temp = 1'($urandom & 1);
        req = '{CMD_READ, 3'h0, 14'h0000};
        req_valid = 1'b1;
        repeat (3200)
        begin
            @(negedge clk);
            chk(req_taken, 0, "refused read");
            chk(refresh_owed <= 4'h8, 1, "owed bound");
        end
        req_valid = 1'b0;
        chk(refs - t0 >= 1, 1, "host refresh");
        chk(viol, 0, "memory spacing");
        $display("test refresh finished");
        report_and_stop();
    end
endmodule // testbench
